//--- include/tq_cfg.svh
/*
  Bit positions, addresses, reset values and sizes of the thread-qualified
  event counter. Assumes inclusion by bare name from its users.
*/
// Overview of operation
// - Thread one user/kernel qualifiers count at privilege 1-3 and 0.
// - Thread zero user/kernel qualifiers count at privilege 1-3 and 0.
// - Tag enable set tags micro-ops matching the selected event; clear, none.
// - The four-bit tag value rides on micro-ops tagged by the event.
// - The sixteen-bit event mask picks sub-events within the class.
// - The six-bit event select field picks the counted event class.
// - Counter increments only with its enable bit set; reset clears it.
// - Three-bit selection field picks which event selection register feeds us.
// - Active-thread field: none, exactly one, both, or at least one.
// - Halted or startup-message-waiting threads count as inactive.
// - Compare bit enables threshold filtering; clear passes counts unfiltered.
// - Complement set: count when at most threshold; else when above.
// - Threshold field is the comparison value, used only with compare.
// - Edge plus compare counts only false-to-true comparison transitions.
// - Forced wrap bit signals overflow on every increment.
// - Thread zero routing bit sends monitor interrupt there on overflow.
// - Thread one routing bit sends monitor interrupt there on overflow.
// - Interrupt rises on the next event count after the wrap.
// - Cascade bit holds counting until the partner counter overflows.
// - Sticky wrap flag sets on overflow; software clears it by write.
// - Sampling disabled on management mode, machine check, reset and init.
// - Tagged-execution class counts one when a masked tag bit retires.
`ifndef TQ_CFG_SVH
`define TQ_CFG_SVH

`define TQ_ES_T1U 0
`define TQ_ES_T1K 1
`define TQ_ES_T0U 2
`define TQ_ES_T0K 3
`define TQ_ES_TAGEN 4
`define TQ_ES_TAG_LO 5
`define TQ_ES_TAG_HI 8
`define TQ_ES_MSK_LO 9
`define TQ_ES_MSK_HI 24
`define TQ_ES_SEL_LO 25
`define TQ_ES_SEL_HI 30
`define TQ_ES_RST 32'h0000_0000

`define TQ_CC_EN 12
`define TQ_CC_ESEL_LO 13
`define TQ_CC_ESEL_HI 15
`define TQ_CC_ACT_LO 16
`define TQ_CC_ACT_HI 17
`define TQ_CC_CMP 18
`define TQ_CC_CMPL 19
`define TQ_CC_THR_LO 20
`define TQ_CC_THR_HI 23
`define TQ_CC_EDGE 24
`define TQ_CC_FWRAP 25
`define TQ_CC_IRQ0 26
`define TQ_CC_IRQ1 27
`define TQ_CC_CASC 30
`define TQ_CC_WRAP 31
`define TQ_CC_WMASK 32'h4FFF_F000
`define TQ_CC_RST 32'h0000_0000

`define TQ_SE_PS 24

`define TQ_A_CFG 4'h8
`define TQ_A_CNT 4'h9
`define TQ_A_SEN 4'hA

`define TQ_NUM_ESEL 8
`define TQ_CNT_W 32
`define TQ_CPL_KERN 2'h0
`define TQ_EXEC_CLASS 6'h0C

`endif

//--- include/tq_pkg.sv
/*
  Types of the thread-qualified event counter.
  Assumes nothing of its surroundings.
*/
package tq_pkg;
  typedef enum logic [1:0]
  {
    TQ_ACT_NONE = 2'h0,
    TQ_ACT_ONE = 2'h1,
    TQ_ACT_BOTH = 2'h2,
    TQ_ACT_ANY = 2'h3
  } tq_act_t;

  typedef enum logic [1:0]
  {
    TQ_CAS_WAIT = 2'h0,
    TQ_CAS_RUN = 2'h1
  } tq_cas_t;
endpackage

//--- core/tq_qual.sv
/*
  Privilege and thread qualification of sub-event hits, with count.
  Assumes hits arrive on the core clock for the selected event class.
*/
`timescale 1ns/1ps
`include "tq_cfg.svh"
module tq_qual
  import tq_pkg::*;
(
  input wire logic [31:0] sel_word, // Selected event selection word
  input wire logic [15:0] t0_hits, // Thread zero sub-event hits
  input wire logic [15:0] t1_hits, // Thread one sub-event hits
  input wire logic [1:0] t0_cpl, // Thread zero privilege
  input wire logic [1:0] t1_cpl, // Thread one privilege
  input wire logic [3:0] retire_tags, // Tags on retiring micro-op
  output logic [5:0] raw_cnt, // Qualified hits this cycle
  output logic any_hit // Some qualified hit
);
  // ==========================================================
  // Qualification
  logic t0_ok;
  logic t1_ok;
  logic [15:0] mask;
  logic [15:0] q0;
  logic [15:0] q1;
  logic exec_cls;

  assign mask = sel_word[`TQ_ES_MSK_HI:`TQ_ES_MSK_LO];
  assign t0_ok = (t0_cpl == `TQ_CPL_KERN) ?
    sel_word[`TQ_ES_T0K] : sel_word[`TQ_ES_T0U];
  assign t1_ok = (t1_cpl == `TQ_CPL_KERN) ?
    sel_word[`TQ_ES_T1K] : sel_word[`TQ_ES_T1U];
  assign exec_cls =
    (sel_word[`TQ_ES_SEL_HI:`TQ_ES_SEL_LO] == `TQ_EXEC_CLASS);

  for (genvar g = 0; g < 16; g++)
  begin : g_bit
    assign q0[g] = t0_hits[g] & mask[g] & t0_ok;
    assign q1[g] = t1_hits[g] & mask[g] & t1_ok;
  end

  // ==========================================================
  // Count
  always_comb
  begin
    raw_cnt = 6'h00;
    if (exec_cls)
      raw_cnt = {5'h00, |(retire_tags & mask[3:0])};
    else
      for (int i = 0; i < 16; i++)
        raw_cnt = raw_cnt + {5'h00, q0[i]} + {5'h00, q1[i]};
    any_hit = (raw_cnt != 6'h00);
  end
endmodule

//--- core/tq_thresh.sv
/*
  Threshold compare, complement and rising-edge filter of the count.
  Assumes one incoming count per core clock.
*/
`timescale 1ns/1ps
`include "tq_cfg.svh"
module tq_thresh
  import tq_pkg::*;
(
  input wire logic clk, // Core clock
  input wire logic rst_n, // Async reset, active low
  input wire logic [5:0] raw_cnt, // Incoming count
  input wire logic cmp_en, // Filtering on
  input wire logic cmpl, // At-most compare
  input wire logic [3:0] thr, // Threshold
  input wire logic edge_en, // Rising edge only
  output logic [5:0] filt_cnt // Delivered count
);
  // ==========================================================
  // Compare
  logic hit;
  logic hit_prev_reg;

  assign hit = cmpl ? (raw_cnt <= {2'h0, thr}) :
    (raw_cnt > {2'h0, thr});

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      hit_prev_reg <= 1'b0;
    else
      hit_prev_reg <= hit;
  end

  always_comb
  begin
    if (!cmp_en)
      filt_cnt = raw_cnt;
    else if (edge_en)
      filt_cnt = {5'h00, hit & ~hit_prev_reg};
    else
      filt_cnt = {5'h00, hit};
  end

  // ==========================================================
  // Checks
  AST_EDGE_ONCE: assert property (
    @(posedge clk) disable iff (!rst_n)
    cmp_en && edge_en && filt_cnt != 6'h00 ##1 cmp_en && edge_en
    |-> filt_cnt == 6'h00)
    else $error("edge filter counted twice");
  AST_CMP_OFF: assert property (
    @(posedge clk) disable iff (!rst_n)
    !cmp_en |-> filt_cnt == raw_cnt)
    else $error("count filtered with compare off");
  AST_CMP_SINGLE: assert property (
    @(posedge clk) disable iff (!rst_n)
    cmp_en |-> filt_cnt <= 6'h01)
    else $error("compare delivered more than one count");
endmodule

//--- core/tq_counter_top.sv
/*
  Thread-qualified event counter: selection registers, configuration,
  counter, sampling enable and monitor interrupt routing.
  Assumes all inputs come from core logic on SYS_CLK.
*/
`timescale 1ns/1ps
`include "tq_cfg.svh"
module tq_counter_top
  import tq_pkg::*;
(
  input wire logic SYS_CLK, // Core clock
  input wire logic RESETN, // Async reset, active low
  input wire logic [3:0] REG_ADDR, // Register index
  input wire logic REG_WR, // Register write strobe
  input wire logic REG_RD, // Register read strobe
  input wire logic [31:0] REG_WDATA, // Write data
  output logic [31:0] REG_RDATA, // Read data
  input wire logic [1:0] T0_CPL, // Thread zero privilege
  input wire logic [1:0] T1_CPL, // Thread one privilege
  input wire logic T0_HALTED, // Thread zero halted
  input wire logic T1_HALTED, // Thread one halted
  input wire logic T0_STARTUP_WAIT, // Thread zero awaits startup
  input wire logic T1_STARTUP_WAIT, // Thread one awaits startup
  input wire logic [15:0] T0_HITS, // Thread zero sub-events
  input wire logic [15:0] T1_HITS, // Thread one sub-events
  input wire logic [3:0] RETIRE_TAGS, // Retiring micro-op tags
  input wire logic ALT_WRAP, // Partner counter overflow
  input wire logic SMM_ENTRY, // Management mode entry
  input wire logic MCHECK, // Machine check raised
  input wire logic INIT_REQ, // Init request
  output logic [5:0] EVENT_CLASS, // Selected event class
  output logic TAG_VALID, // Tag micro-op now
  output logic [3:0] TAG_VALUE, // Tag to attach
  output logic WRAP_PULSE, // Overflow event
  output logic PERF_IRQ_T0, // Monitor interrupt thread 0
  output logic PERF_IRQ_T1, // Monitor interrupt thread 1
  output logic SAMPLE_EN // Precise sampling enabled
);
  // ==========================================================
  // Declarations
  logic [31:0] esel_reg [0:`TQ_NUM_ESEL-1];
  logic [31:0] cfg_reg;
  logic wrap_flag_reg;
  logic [`TQ_CNT_W-1:0] cnt_reg;
  logic samp_reg;
  logic pend_reg;
  tq_cas_t cas_reg;
  logic [31:0] sel_word;
  logic wr_esel;
  logic wr_cfg;
  logic wr_cnt;
  logic wr_sen;
  logic [5:0] raw_cnt;
  logic [5:0] filt_cnt;
  logic [5:0] inc_cnt;
  logic any_hit;
  logic act0;
  logic act1;
  logic act_ok;
  logic [`TQ_CNT_W:0] sum;
  logic wrap_evt;
  logic inc_nz;

  // ==========================================================
  // Decode
  assign wr_esel = REG_WR && !REG_ADDR[3];
  assign wr_cfg = REG_WR && (REG_ADDR == `TQ_A_CFG);
  assign wr_cnt = REG_WR && (REG_ADDR == `TQ_A_CNT);
  assign wr_sen = REG_WR && (REG_ADDR == `TQ_A_SEN);
  assign sel_word =
    esel_reg[cfg_reg[`TQ_CC_ESEL_HI:`TQ_CC_ESEL_LO]];

  // ==========================================================
  // Event selection registers
  for (genvar g = 0; g < `TQ_NUM_ESEL; g++)
  begin : g_esel
    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
      if (!RESETN)
        esel_reg[g] <= `TQ_ES_RST;
      else if (wr_esel && REG_ADDR[2:0] == 3'(g))
        esel_reg[g] <= REG_WDATA;
    end
  end

  // ==========================================================
  // Configuration and sticky flag
  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
      cfg_reg <= `TQ_CC_RST;
    else if (wr_cfg)
      cfg_reg <= REG_WDATA & `TQ_CC_WMASK;
  end

  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
      wrap_flag_reg <= 1'b0;
    else if (wrap_evt)
      wrap_flag_reg <= 1'b1;
    else if (wr_cfg && !REG_WDATA[`TQ_CC_WRAP])
      wrap_flag_reg <= 1'b0;
  end

  // ==========================================================
  // Qualification and filtering
  tq_qual u_qual
  (
    .sel_word(sel_word),
    .t0_hits(T0_HITS),
    .t1_hits(T1_HITS),
    .t0_cpl(T0_CPL),
    .t1_cpl(T1_CPL),
    .retire_tags(RETIRE_TAGS),
    .raw_cnt(raw_cnt),
    .any_hit(any_hit)
  );

  tq_thresh u_thresh
  (
    .clk(SYS_CLK),
    .rst_n(RESETN),
    .raw_cnt(raw_cnt),
    .cmp_en(cfg_reg[`TQ_CC_CMP]),
    .cmpl(cfg_reg[`TQ_CC_CMPL]),
    .thr(cfg_reg[`TQ_CC_THR_HI:`TQ_CC_THR_LO]),
    .edge_en(cfg_reg[`TQ_CC_EDGE]),
    .filt_cnt(filt_cnt)
  );

  assign act0 = !T0_HALTED && !T0_STARTUP_WAIT;
  assign act1 = !T1_HALTED && !T1_STARTUP_WAIT;

  always_comb
  begin
    case (tq_act_t'(cfg_reg[`TQ_CC_ACT_HI:`TQ_CC_ACT_LO]))
      TQ_ACT_NONE: act_ok = !act0 && !act1;
      TQ_ACT_ONE: act_ok = act0 ^ act1;
      TQ_ACT_BOTH: act_ok = act0 && act1;
      default: act_ok = act0 || act1;
    endcase
  end

  assign inc_cnt = (cfg_reg[`TQ_CC_EN] && act_ok &&
    cas_reg == TQ_CAS_RUN) ? filt_cnt : 6'h00;
  assign inc_nz = (inc_cnt != 6'h00);
  assign sum = {1'b0, cnt_reg} + {{(`TQ_CNT_W-5){1'b0}}, inc_cnt};
  assign wrap_evt = inc_nz && !wr_cnt &&
    (sum[`TQ_CNT_W] || cfg_reg[`TQ_CC_FWRAP]);

  // ==========================================================
  // Cascade state
  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
      cas_reg <= TQ_CAS_RUN;
    else if (wr_cfg)
      cas_reg <= REG_WDATA[`TQ_CC_CASC] ? TQ_CAS_WAIT : TQ_CAS_RUN;
    else
    begin
      case (cas_reg)
        TQ_CAS_WAIT: if (ALT_WRAP) cas_reg <= TQ_CAS_RUN;
        TQ_CAS_RUN: cas_reg <= TQ_CAS_RUN;
        default: cas_reg <= TQ_CAS_RUN;
      endcase
    end
  end

  // ==========================================================
  // Counter
  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
      cnt_reg <= '0;
    else if (wr_cnt)
      cnt_reg <= REG_WDATA[`TQ_CNT_W-1:0];
    else
      cnt_reg <= sum[`TQ_CNT_W-1:0];
  end

  // ==========================================================
  // Interrupt routing
  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
      pend_reg <= 1'b0;
    else if (wrap_evt)
      pend_reg <= 1'b1;
    else if (inc_nz)
      pend_reg <= 1'b0;
  end

  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      PERF_IRQ_T0 <= 1'b0;
      PERF_IRQ_T1 <= 1'b0;
      WRAP_PULSE <= 1'b0;
    end
    else
    begin
      PERF_IRQ_T0 <= pend_reg && inc_nz &&
        cfg_reg[`TQ_CC_IRQ0];
      PERF_IRQ_T1 <= pend_reg && inc_nz &&
        cfg_reg[`TQ_CC_IRQ1];
      WRAP_PULSE <= wrap_evt;
    end
  end

  // ==========================================================
  // Tagging and class output
  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      TAG_VALID <= 1'b0;
      TAG_VALUE <= 4'h0;
      EVENT_CLASS <= 6'h00;
    end
    else
    begin
      TAG_VALID <= sel_word[`TQ_ES_TAGEN] && any_hit;
      TAG_VALUE <= (sel_word[`TQ_ES_TAGEN] && any_hit) ?
        sel_word[`TQ_ES_TAG_HI:`TQ_ES_TAG_LO] : 4'h0;
      EVENT_CLASS <= sel_word[`TQ_ES_SEL_HI:`TQ_ES_SEL_LO];
    end
  end

  // ==========================================================
  // Sampling enable
  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
      samp_reg <= 1'b0;
    else if (SMM_ENTRY || MCHECK || INIT_REQ)
      samp_reg <= 1'b0;
    else if (wr_sen)
      samp_reg <= REG_WDATA[`TQ_SE_PS];
  end

  assign SAMPLE_EN = samp_reg;

  // ==========================================================
  // Read back
  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
      REG_RDATA <= 32'h0000_0000;
    else if (REG_RD)
    begin
      REG_RDATA <= 32'h0000_0000;
      if (!REG_ADDR[3])
        REG_RDATA <= esel_reg[REG_ADDR[2:0]];
      else if (REG_ADDR == `TQ_A_CFG)
        REG_RDATA <= {wrap_flag_reg, cfg_reg[30:0]};
      else if (REG_ADDR == `TQ_A_CNT)
        REG_RDATA <= cnt_reg;
      else if (REG_ADDR == `TQ_A_SEN)
        REG_RDATA[`TQ_SE_PS] <= samp_reg;
    end
  end

  // ==========================================================
  // Checks
  AST_EN_GATE: assert property (
    @(posedge SYS_CLK) disable iff (!RESETN)
    !cfg_reg[`TQ_CC_EN] && !wr_cnt |=> $stable(cnt_reg))
    else $error("counter moved while disabled");
  AST_STICKY_SET: assert property (
    @(posedge SYS_CLK) disable iff (!RESETN)
    wrap_evt |=> wrap_flag_reg ##1 (wrap_flag_reg || $past(wr_cfg)))
    else $error("wrap flag not held");
  AST_IRQ_LATE: assert property (
    @(posedge SYS_CLK) disable iff (!RESETN)
    wrap_evt && !pend_reg |=> !PERF_IRQ_T0 && !PERF_IRQ_T1)
    else $error("interrupt in wrap cycle");
  AST_IRQ0_ROUTE: assert property (
    @(posedge SYS_CLK) disable iff (!RESETN)
    PERF_IRQ_T0 |-> $past(cfg_reg[`TQ_CC_IRQ0]) && $past(pend_reg))
    else $error("thread 0 interrupt not routed");
  AST_IRQ1_ROUTE: assert property (
    @(posedge SYS_CLK) disable iff (!RESETN)
    PERF_IRQ_T1 |-> $past(cfg_reg[`TQ_CC_IRQ1]) && $past(pend_reg))
    else $error("thread 1 interrupt not routed");
  AST_FORCE_WRAP: assert property (
    @(posedge SYS_CLK) disable iff (!RESETN)
    inc_nz && cfg_reg[`TQ_CC_FWRAP] && !wr_cnt |=> WRAP_PULSE)
    else $error("forced wrap missing");
  AST_SAMPLE_OFF: assert property (
    @(posedge SYS_CLK) disable iff (!RESETN)
    SMM_ENTRY || MCHECK || INIT_REQ |=> !SAMPLE_EN)
    else $error("sampling left on");
  AST_CASC_HOLD: assert property (
    @(posedge SYS_CLK) disable iff (!RESETN)
    cas_reg == TQ_CAS_WAIT |-> !inc_nz)
    else $error("cascade counted early");
  AST_WRAP_ZERO: assert property (
    @(posedge SYS_CLK) disable iff (!RESETN)
    &cnt_reg && inc_cnt == 6'h01 && !wr_cnt |=> cnt_reg == '0)
    else $error("counter did not wrap to zero");
  AST_ACT_NONE: assert property (
    @(posedge SYS_CLK) disable iff (!RESETN)
    cfg_reg[`TQ_CC_ACT_HI:`TQ_CC_ACT_LO] == 2'h0 && (act0 || act1)
    |-> !inc_nz)
    else $error("counted with a thread active");
  AST_STICKY_WINS: assert property (
    @(posedge SYS_CLK) disable iff (!RESETN)
    wrap_evt && wr_cfg |=> wrap_flag_reg)
    else $error("clearing write beat a wrap");
endmodule

//--- tb/tq_counter_top_test.sv
/*
  Self-checking bench of the thread-qualified event counter.
  Assumes tq_cfg.svh and tq_pkg on the compile path.
*/
`timescale 1ns/1ps
module tq_counter_top_test;
  import tq_pkg::*;
  // ============================================================
  // Signals
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, alt = 1'b0;
  logic [3:0] addr = 4'h0, tags = 4'h0, st = 4'hC, tag_val;
  logic [31:0] wdata = 32'h0, rdata, seed = 32'h9B18;
  logic [1:0] cpl0 = 2'h0, cpl1 = 2'h0;
  logic [15:0] h0 = 16'h0, h1 = 16'h0;
  logic [2:0] dis = 3'h0;
  logic [5:0] ev_class;
  logic tag_v, wrap, irq0, irq1, samp, rd_due = 1'b0;
  logic [31:0] rd_q[$];
  logic [7:0] pl_q[$];
  int failures = 0, num_checks = 0;

  always #2.5 clk = ~clk;

  // ============================================================
  // Design
  tq_counter_top u_tq_counter_top
  (
    .SYS_CLK(clk), .RESETN(rst_n), .REG_ADDR(addr), .REG_WR(wr),
    .REG_RD(rd), .REG_WDATA(wdata), .REG_RDATA(rdata),
    .T0_CPL(cpl0), .T1_CPL(cpl1), .T0_HALTED(st[3]), .T1_HALTED(st[2]),
    .T0_STARTUP_WAIT(st[1]), .T1_STARTUP_WAIT(st[0]),
    .T0_HITS(h0), .T1_HITS(h1), .RETIRE_TAGS(tags), .ALT_WRAP(alt),
    .SMM_ENTRY(dis[0]), .MCHECK(dis[1]), .INIT_REQ(dis[2]),
    .EVENT_CLASS(ev_class), .TAG_VALID(tag_v), .TAG_VALUE(tag_val),
    .WRAP_PULSE(wrap), .PERF_IRQ_T0(irq0), .PERF_IRQ_T1(irq1),
    .SAMPLE_EN(samp)
  );

  // ============================================================
  // Tasks
  function automatic logic [31:0] rnd();
    repeat (32) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  function automatic int pc(input logic [15:0] x);
    int c;
    c = 0;
    for (int i = 0; i < 16; i++) c += int'(x[i]);
    return c;
  endfunction

  task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH %0t read %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_pl(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH %0t pulses %h expected %h", $time, got, exp);
    end
  endtask

  task automatic final_report;
    if (failures == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask

  task automatic rreg(input logic [3:0] a, input logic [31:0] e);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    rd_q.push_back(e);
    @(negedge clk);
    rd = 1'b0;
  endtask

  // One cycle of events, then both threads halted and idle
  task automatic burst(input logic [15:0] a, b, input logic [3:0] s, t);
    @(negedge clk);
    h0 = a;
    h1 = b;
    st = s;
    tags = t;
    @(negedge clk);
    h0 = 16'h0;
    h1 = 16'h0;
    st = 4'hC;
    tags = 4'h0;
  endtask

  // ============================================================
  // Watcher
  always @(posedge clk) rd_due <= rd;

  always @(negedge clk)
  begin
    if (rd_due)
      chk_rd(rdata, rd_q.pop_front());
    if ((tag_v | wrap | irq0 | irq1) !== 1'b0)
      chk_pl({tag_v, tag_val, wrap, irq0, irq1},
        pl_q.size() != 0 ? pl_q.pop_front() : 8'h00);
  end

  initial
  begin
    repeat (100000) @(posedge clk);
    failures++;
    final_report;
  end

  // ============================================================
  // Stimulus
  initial
  begin
    logic [31:0] r, b, es, cfg, ex;
    int n, v;
    logic pass, tg, cr, pv0;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    rreg(4'h8, 32'h0);
    rreg(4'h9, 32'h0);
    rreg(4'h0, 32'h0);
    wreg(4'hB, 32'hFFFF_FFFF);
    rreg(4'hB, 32'h0);
    for (int i = 0; i < 60; i++)
    begin
      r = rnd();
      b = rnd();
      es = rnd();
      cfg = {14'h0, r[4:3], r[2:0], r[5] | r[6], 12'h0};
      tg = b[0] & b[1];
      es[30:25] = tg ? 6'h0C : (es[30:25] == 6'h0C ? 6'h01 : es[30:25]);
      es[31] = 1'b0;
      n = int'(!(r[10] | r[8])) + int'(!(r[9] | r[7]));
      pass = cfg[12] && (r[4:3] == 2'h3 ? n != 0 : n == int'(r[4:3]));
      es[4] = es[4] & pass & !tg;
      cpl0 = r[12:11];
      cpl1 = r[14:13];
      if (tg)
        v = int'(|(b[19:16] & es[12:9]));
      else
        v = pc(r[31:16] & es[24:9]) * int'(r[12:11] == 2'h0 ? es[3] : es[2])
          + pc(b[31:16] & es[24:9]) * int'(r[14:13] == 2'h0 ? es[1] : es[0]);
      if (es[4] && v != 0)
        pl_q.push_back({1'b1, es[8:5], 3'h0});
      wreg({1'b0, r[2:0]}, es);
      wreg(4'h8, cfg);
      wreg(4'h9, 32'h0);
      burst(tg ? 16'h0 : r[31:16], tg ? 16'h0 : b[31:16], r[10:7], b[19:16]);
      rreg(4'h9, pass ? 32'(v) : 32'h0);
      chk_rd({26'h0, ev_class}, {26'h0, es[30:25]});
    end
    cpl0 = 2'h0;
    wreg(4'h0, 32'h03FF_FE0F);
    for (int i = 0; i < 30; i++)
    begin
      r = rnd();
      cfg = {7'h0, r[6], r[5:2], r[1], r[0], 2'h3, 3'h0, 1'b1, 12'h0};
      wreg(4'h8, cfg);
      wreg(4'h9, 32'h0);
      cr = r[1];
      ex = 32'h0;
      for (int k = 0; k < 3; k++)
      begin
        b = rnd() & rnd();
        v = pc(b[15:0]);
        pv0 = r[1] ? v <= int'(r[5:2]) : v > int'(r[5:2]);
        ex = ex + (r[0] ? (r[6] ? 32'(pv0 & !cr) : 32'(pv0)) : 32'(v));
        cr = pv0;
        @(negedge clk);
        h0 = b[15:0];
        st = 4'h0;
      end
      @(negedge clk);
      h0 = 16'h0;
      st = 4'hC;
      rreg(4'h9, ex);
    end
    wreg(4'h8, 32'hFFFF_FFFF);
    rreg(4'h8, 32'h4FFF_F000);
    wreg(4'h8, 32'h4003_1000);
    wreg(4'h9, 32'h0);
    burst(16'h0001, 16'h0, 4'h0, 4'h0);
    rreg(4'h9, 32'h0);
    @(negedge clk);
    alt = 1'b1;
    @(negedge clk);
    alt = 1'b0;
    burst(16'h0001, 16'h0, 4'h0, 4'h0);
    rreg(4'h9, 32'h1);
    for (int k = 0; k < 4; k++)
    begin
      cfg = 32'h0003_1000 | (32'(k) << 26);
      wreg(4'h8, cfg);
      wreg(4'h9, 32'hFFFF_FFFF);
      pl_q.push_back(8'h04);
      burst(16'h0001, 16'h0, 4'h0, 4'h0);
      rreg(4'h9, 32'h0);
      rreg(4'h8, cfg | 32'h8000_0000);
      if (k != 0)
        pl_q.push_back({6'h0, k[0], k[1]});
      burst(16'h0001, 16'h0, 4'h0, 4'h0);
      wreg(4'h8, cfg);
      rreg(4'h8, cfg);
    end
    wreg(4'h8, 32'h0203_1000);
    wreg(4'h9, 32'h5);
    pl_q.push_back(8'h04);
    pl_q.push_back(8'h04);
    burst(16'h0001, 16'h0, 4'h0, 4'h0);
    burst(16'h0001, 16'h0, 4'h0, 4'h0);
    for (int k = 0; k < 3; k++)
    begin
      wreg(4'hA, 32'hFFFF_FFFF);
      rreg(4'hA, 32'h0100_0000);
      chk_rd({31'h0, samp}, 32'h1);
      @(negedge clk);
      dis = 3'(1 << k);
      @(negedge clk);
      dis = 3'h0;
      rreg(4'hA, 32'h0);
      chk_rd({31'h0, samp}, 32'h0);
    end
    repeat (4) @(negedge clk);
    chk_rd(32'(pl_q.size() + rd_q.size()), 32'h0);
    final_report;
  end
endmodule
